// [common/srap_pkg.sv]
// shared constants and types for the scanner register access port
package srap_pkg;
    localparam int        ADDR_W        = 7;
    localparam int        DATA_W        = 8;
    localparam int        WADDR_W       = 14;
    localparam int        NPINS         = 6;
    // register offsets
    localparam bit [6:0]  REG_STATUS    = 7'h02;
    localparam bit [6:0]  REG_TGTCOL    = 7'h03;
    localparam bit [6:0]  REG_WADDR_HI  = 7'h04;
    localparam bit [6:0]  REG_WADDR_LO  = 7'h05;
    localparam bit [6:0]  REG_WDATA     = 7'h06;
    localparam bit [6:0]  REG_COMMAND   = 7'h07;
    localparam bit [6:0]  REG_SENSE_CFG = 7'h58;
    localparam bit [6:0]  REG_PIN_DIR   = 7'h59;
    localparam bit [6:0]  REG_PIN_POL   = 7'h5a;
    localparam bit [6:0]  REG_PIN_EDGE  = 7'h5b;
    localparam bit [6:0]  REG_PIN_OUT   = 7'h5c;
    localparam bit [6:0]  REG_S2_LINES  = 7'h5d;
    // field positions
    localparam int        TGT_LSB       = 0;
    localparam int        COL_LSB       = 2;
    localparam int        TGTCOL_RO_BIT = 4;
    localparam int        WDIR_BIT      = 6;
    localparam int        ST_SENSE1     = 0;
    localparam int        ST_SENSE2     = 1;
    localparam int        ST_PIN_LSB    = 2;
    localparam int        CFG_S1_STOP   = 0;
    localparam int        CFG_S2_STOP   = 1;
    localparam int        CFG_S1_POL    = 2;
    localparam int        CFG_S2_POL    = 3;
    localparam int        CFG_S1_EDGE   = 4;
    // window targets and colors
    localparam bit [1:0]  TGT_OFFSET    = 2'h0;
    localparam bit [1:0]  TGT_GAIN      = 2'h1;
    localparam bit [1:0]  TGT_GAMMA     = 2'h2;
    localparam bit [1:0]  COL_BAD       = 2'h3;
    localparam bit [13:0] GAMMA_TOP     = 14'h0ffd;
    localparam bit [13:0] COEF_TOP      = 14'h3fff;
    // commands
    localparam bit [7:0]  CMD_IDLE      = 8'h00;
    localparam bit [7:0]  CMD_FFWD      = 8'h01;
    localparam bit [7:0]  CMD_FREV      = 8'h02;
    // pin defaults: 1..3 edge inputs active low, 4,5 high, 6 low
    localparam bit [5:0]  DEF_DIR       = 6'h38;
    localparam bit [5:0]  DEF_POL       = 6'h00;
    localparam bit [5:0]  DEF_EDGE      = 6'h07;
    localparam bit [5:0]  DEF_OUT       = 6'h18;
    localparam int        BUF_DEPTH     = 2;

    typedef enum logic [2:0] {
        SRAP_M_IDLE = 3'b001,
        SRAP_M_RD   = 3'b010,
        SRAP_M_WR   = 3'b100
    } srap_mst_t;
endpackage : srap_pkg

// [common/srap_word_if.sv]
// address and word stream between the access port and its buffer
`timescale 1ns/1ps
interface srap_word_if;
    logic        valid;
    logic        ready;
    logic [29:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : srap_word_if

// [design/srap_skid.sv]
// two-entry buffer for write words heading to table memory
`timescale 1ns/1ps
module srap_skid (
    // clock and reset
    input  wire logic     mclk,
    input  wire logic     rst,
    // filling side
    srap_word_if.dst      in_w,
    // draining side
    srap_word_if.src      out_w
);
    typedef struct packed {
        logic [1:0][29:0] mem;
        logic             wp;
        logic             rp;
        logic [1:0]       cnt;
    } srap_skid_t;

    srap_skid_t st_ff;
    srap_skid_t nxt_st;

    assign in_w.ready  = (st_ff.cnt != 2'(srap_pkg::BUF_DEPTH));
    assign out_w.valid = (st_ff.cnt != 2'h0);
    assign out_w.data  = st_ff.mem[st_ff.rp];

    always_comb begin
        logic push;
        logic pop;
        push = in_w.valid && in_w.ready;
        pop  = out_w.valid && out_w.ready;
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_w.data;
            nxt_st.wp = ~st_ff.wp;
        end
        if (pop) begin
            nxt_st.rp = ~st_ff.rp;
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : srap_skid

// [design/srap_top.sv]
// indexed register port, table window and sense/general pin logic
`timescale 1ns/1ps
// Contract
// - direction bit 0 input, 1 output
// - polarity 1 high true, 0 low true
// - level follows input; edge latches rising truth
// - status read clears edge bits
// - sense one true edge stops active motion
// - sense two stops after lines, never reverse
// - output pins drive written output bit
// - pins default on reset or suspend only
// - defaults: pins 1-3 falling edge, 4,5 high
// - address written once, then repeated data access
// - bits 1:0 select offset, gain, gamma
// - bits 3:2 select red, green, blue
// - window address fourteen bits over two registers
// - direction bit requests read prefetch
// - window address increments per two bytes
// - address wraps at 4093 or 16383
// - data port moves consecutive bytes
// - high byte first, format per table
// - command 0 idle, 1 forward, 2 reverse
module srap_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        suspend,
    input  wire logic        soft_hold,
    // register port: address phase then data phases
    input  wire logic        reg_addr_wr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // table memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic      [1:0]  mem_table,
    output logic      [1:0]  mem_color,
    output logic      [13:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // engine link
    input  wire logic        line_tick,
    output logic             acquire_active,
    output logic      [7:0]  command,
    // pins
    input  wire logic        sense1_pin,
    input  wire logic        sense2_pin,
    input  wire logic [5:0]  gpio_in,
    output logic      [5:0]  gpio_out,
    output logic      [5:0]  gpio_oe
);
    typedef struct packed {
        logic [6:0]  addr;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [3:0]  tgtcol;
        logic        wdir;
        logic [13:0] waddr;
        logic        phase;
        logic [7:0]  hi_byte;
        logic [15:0] pre;
        logic        pre_ok;
        srap_pkg::srap_mst_t mst;
        logic [13:0] maddr;
        logic [7:0]  cmd;
        logic        active;
        logic [5:0]  scfg;
        logic [5:0]  dir;
        logic [5:0]  pol;
        logic [5:0]  edge_en;
        logic [5:0]  pout;
        logic [7:0]  s2_lines;
        logic [7:0]  s2_cnt;
        logic        s2_run;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [7:0]  truth_d;
        logic [7:0]  sticky;
        logic        s2_flag;
    } srap_top_t;

    srap_top_t st_ff;
    srap_top_t nxt_st;

    srap_word_if wq_in ();
    srap_word_if wq_out ();

    srap_skid u_skid (
        .mclk  (mclk),
        .rst   (rst),
        .in_w  (wq_in),
        .out_w (wq_out)
    );

    // hazard: pin levels are asynchronous, so only sync2 feeds logic
    logic [7:0] truth;
    logic [7:0] pol8;
    logic [7:0] lvl8;
    logic [7:0] out8;
    logic [7:0] status_val;
    logic       sel_bad;
    logic [13:0] wtop;
    logic [15:0] wword;

    always_comb begin
        pol8 = {st_ff.pol, st_ff.scfg[srap_pkg::CFG_S2_POL],
                st_ff.scfg[srap_pkg::CFG_S1_POL]};
        truth = ~(st_ff.sync2 ^ pol8);
        lvl8 = {~st_ff.edge_en, 1'b0, ~st_ff.scfg[srap_pkg::CFG_S1_EDGE]};
        out8 = {st_ff.dir, 2'b00};
        for (int i = 0; i < 8; i++) begin
            if (out8[i]) begin
                status_val[i] = 1'b0;
            end else if (i == 1) begin
                status_val[i] = st_ff.s2_flag;
            end else if (lvl8[i]) begin
                status_val[i] = truth[i];
            end else begin
                status_val[i] = st_ff.sticky[i];
            end
        end
    end

    assign sel_bad = (st_ff.tgtcol[1:0] == srap_pkg::COL_BAD)
                  || (st_ff.tgtcol[3:2] == srap_pkg::COL_BAD);
    assign wtop = (st_ff.tgtcol[1:0] == srap_pkg::TGT_GAMMA)
                ? srap_pkg::GAMMA_TOP : srap_pkg::COEF_TOP;

    // pack the assembled word per table format
    always_comb begin
        unique case (st_ff.tgtcol[1:0])
            srap_pkg::TGT_OFFSET: wword = {st_ff.hi_byte,
                                           reg_wdata[7:2], 2'b00};
            srap_pkg::TGT_GAMMA:  wword = {4'h0, st_ff.hi_byte[3:0],
                                           reg_wdata};
            default:              wword = {st_ff.hi_byte, reg_wdata};
        endcase
    end

    logic wr_port;
    logic rd_port;
    assign wr_port = reg_wr && st_ff.addr == srap_pkg::REG_WDATA;
    assign rd_port = reg_rd && st_ff.addr == srap_pkg::REG_WDATA;

    assign wq_in.valid = wr_port && st_ff.phase && !sel_bad;
    assign wq_in.data  = {st_ff.waddr, wword};
    assign wq_out.ready = (st_ff.mst == srap_pkg::SRAP_M_WR) && mem_ack;

    always_comb begin
        logic [13:0] inc;
        logic        s1_rise;
        logic        s2_rise;
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        inc = (st_ff.waddr >= wtop) ? 14'h0000 : st_ff.waddr + 14'h0001;
        nxt_st.sync1 = {gpio_in, sense2_pin, sense1_pin};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.truth_d = truth;
        // clear before set: sticky bits are recomputed after read below
        if (reg_addr_wr) begin
            nxt_st.addr = reg_wdata[6:0];
        end
        if (reg_rd) begin
            nxt_st.rvalid = 1'b1;
            unique case (st_ff.addr)
                srap_pkg::REG_STATUS: begin
                    nxt_st.rdata = status_val;
                    nxt_st.sticky = '0;
                    nxt_st.s2_flag = 1'b0;
                end
                srap_pkg::REG_TGTCOL:   nxt_st.rdata = {4'h0, st_ff.tgtcol};
                srap_pkg::REG_WADDR_HI: nxt_st.rdata = {1'b0, st_ff.wdir,
                                                 st_ff.waddr[13:8]};
                srap_pkg::REG_WADDR_LO: nxt_st.rdata = st_ff.waddr[7:0];
                srap_pkg::REG_WDATA: begin
                    // limitation: a read outruns prefetch returns stale word
                    nxt_st.rdata = sel_bad ? 8'h00 :
                        (st_ff.phase ? st_ff.pre[7:0]
                                     : st_ff.pre[15:8]);
                end
                srap_pkg::REG_COMMAND:  nxt_st.rdata = st_ff.cmd;
                srap_pkg::REG_SENSE_CFG: nxt_st.rdata = {2'b00, st_ff.scfg};
                srap_pkg::REG_PIN_DIR:  nxt_st.rdata = {2'b00, st_ff.dir};
                srap_pkg::REG_PIN_POL:  nxt_st.rdata = {2'b00, st_ff.pol};
                srap_pkg::REG_PIN_EDGE: nxt_st.rdata = {2'b00, st_ff.edge_en};
                srap_pkg::REG_PIN_OUT:  nxt_st.rdata = {2'b00, st_ff.pout};
                srap_pkg::REG_S2_LINES: nxt_st.rdata = st_ff.s2_lines;
                default:                nxt_st.rdata = 8'h00;
            endcase
        end
        if (rd_port) begin
            nxt_st.phase = ~st_ff.phase;
            if (st_ff.phase) begin
                nxt_st.waddr = inc;
                nxt_st.pre_ok = 1'b0;
            end
        end
        if (reg_wr) begin
            unique case (st_ff.addr)
                srap_pkg::REG_TGTCOL: begin
                    nxt_st.tgtcol = reg_wdata[3:0];
                    nxt_st.phase = 1'b0;
                end
                srap_pkg::REG_WADDR_HI: begin
                    nxt_st.waddr[13:8] = reg_wdata[5:0];
                    nxt_st.wdir = reg_wdata[srap_pkg::WDIR_BIT];
                    nxt_st.phase = 1'b0;
                    nxt_st.pre_ok = 1'b0;
                end
                srap_pkg::REG_WADDR_LO: begin
                    nxt_st.waddr[7:0] = reg_wdata;
                    nxt_st.phase = 1'b0;
                    nxt_st.pre_ok = 1'b0;
                end
                srap_pkg::REG_WDATA: begin
                    // second byte waits while buffer is full
                    if (!st_ff.phase) begin
                        nxt_st.hi_byte = reg_wdata;
                        nxt_st.phase = 1'b1;
                    end else if (sel_bad || wq_in.ready) begin
                        nxt_st.phase = 1'b0;
                        nxt_st.waddr = inc;
                    end
                end
                srap_pkg::REG_COMMAND: begin
                    nxt_st.cmd = reg_wdata;
                    nxt_st.active = reg_wdata != srap_pkg::CMD_IDLE;
                end
                srap_pkg::REG_SENSE_CFG: nxt_st.scfg = reg_wdata[5:0];
                srap_pkg::REG_PIN_DIR:   nxt_st.dir = reg_wdata[5:0];
                srap_pkg::REG_PIN_POL:   nxt_st.pol = reg_wdata[5:0];
                srap_pkg::REG_PIN_EDGE:  nxt_st.edge_en = reg_wdata[5:0];
                srap_pkg::REG_PIN_OUT:   nxt_st.pout = reg_wdata[5:0];
                srap_pkg::REG_S2_LINES:  nxt_st.s2_lines = reg_wdata;
                default: ;
            endcase
        end
        // edge capture after the read clear, so a same-cycle event survives
        for (int i = 0; i < 8; i++) begin
            if (truth[i] && !st_ff.truth_d[i]) begin
                nxt_st.sticky[i] = 1'b1;
            end
        end
        s1_rise = truth[0] && !st_ff.truth_d[0];
        s2_rise = truth[1] && !st_ff.truth_d[1];
        if (s1_rise && st_ff.scfg[srap_pkg::CFG_S1_STOP]) begin
            nxt_st.active = 1'b0;
        end
        if (s2_rise && st_ff.scfg[srap_pkg::CFG_S2_STOP]) begin
            nxt_st.s2_run = 1'b1;
            nxt_st.s2_cnt = st_ff.s2_lines;
        end
        if (st_ff.s2_run) begin
            if (st_ff.s2_cnt == 8'h00) begin
                nxt_st.s2_run = 1'b0;
                nxt_st.s2_flag = 1'b1;
                if (st_ff.cmd != srap_pkg::CMD_FREV) begin
                    nxt_st.active = 1'b0;
                end
            end else if (line_tick) begin
                nxt_st.s2_cnt = st_ff.s2_cnt - 8'h01;
            end
        end
        // table memory master: prefetch reads, drain write buffer
        unique case (st_ff.mst)
            srap_pkg::SRAP_M_IDLE: begin
                if (wq_out.valid) begin
                    nxt_st.mst = srap_pkg::SRAP_M_WR;
                    // words carry their address; a later push cannot move it
                    nxt_st.maddr = wq_out.data[29:16];
                end else if (st_ff.wdir && !st_ff.pre_ok && !sel_bad) begin
                    nxt_st.mst = srap_pkg::SRAP_M_RD;
                    nxt_st.maddr = st_ff.waddr;
                end
            end
            srap_pkg::SRAP_M_RD: begin
                if (mem_ack) begin
                    nxt_st.pre = mem_rdata;
                    // drop a fetch whose address was rewritten in flight
                    nxt_st.pre_ok = (st_ff.maddr == nxt_st.waddr) && !rd_port;
                    nxt_st.mst = srap_pkg::SRAP_M_IDLE;
                end
            end
            srap_pkg::SRAP_M_WR: begin
                if (mem_ack) begin
                    nxt_st.maddr = st_ff.maddr;
                    nxt_st.mst = srap_pkg::SRAP_M_IDLE;
                end
            end
            default: nxt_st.mst = srap_pkg::SRAP_M_IDLE;
        endcase
        if (suspend) begin
            nxt_st.dir = srap_pkg::DEF_DIR;
            nxt_st.pol = srap_pkg::DEF_POL;
            nxt_st.edge_en = srap_pkg::DEF_EDGE;
            nxt_st.pout = srap_pkg::DEF_OUT;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.mst <= srap_pkg::SRAP_M_IDLE;
            // no false edge while the synchronisers fill after reset
            st_ff.truth_d <= '1;
            st_ff.dir <= srap_pkg::DEF_DIR;
            st_ff.pol <= srap_pkg::DEF_POL;
            st_ff.edge_en <= srap_pkg::DEF_EDGE;
            st_ff.pout <= srap_pkg::DEF_OUT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata      = st_ff.rdata;
    assign reg_rvalid     = st_ff.rvalid;
    assign mem_req        = st_ff.mst != srap_pkg::SRAP_M_IDLE;
    assign mem_we         = st_ff.mst == srap_pkg::SRAP_M_WR;
    assign mem_table      = st_ff.tgtcol[1:0];
    assign mem_color      = st_ff.tgtcol[3:2];
    assign mem_addr       = st_ff.maddr;
    assign mem_wdata      = wq_out.data[15:0];
    assign acquire_active = st_ff.active;
    assign command        = st_ff.cmd;
    // soft_hold leaves pin setup alone
    assign gpio_out       = st_ff.pout;
    assign gpio_oe        = st_ff.dir;
endmodule : srap_top

// [verification/srap_monitor.sv]
// concurrent checks on the register access port's top-level pins
`timescale 1ns/1ps
module srap_monitor (
    // clock and reset
    input wire logic        mclk, rst, suspend, soft_hold,
    // register port
    input wire logic        reg_addr_wr, reg_wr, reg_rd,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    input wire logic        reg_rvalid,
    // table memory port
    input wire logic        mem_req, mem_we, mem_ack,
    input wire logic [1:0]  mem_table, mem_color,
    input wire logic [13:0] mem_addr,
    input wire logic [15:0] mem_wdata, mem_rdata,
    // engine link and pins
    input wire logic        line_tick, acquire_active,
    input wire logic [7:0]  command,
    input wire logic        sense1_pin, sense2_pin,
    input wire logic [5:0]  gpio_in, gpio_out, gpio_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_idle_two;
        command == srap_pkg::CMD_IDLE ##1 command == srap_pkg::CMD_IDLE;
    endsequence
    sequence s_req_open;
        mem_req && !mem_ack;
    endsequence
    a_reset_pins: assert property (disable iff (1'b0) rst |=>
        gpio_oe == srap_pkg::DEF_DIR && gpio_out == srap_pkg::DEF_OUT)
        else $error("pins not at defaults after reset");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=>
        !mem_req && !acquire_active && command == srap_pkg::CMD_IDLE)
        else $error("engine or memory busy after reset");
    a_suspend_pins: assert property (suspend |=>
        gpio_oe == srap_pkg::DEF_DIR && gpio_out == srap_pkg::DEF_OUT)
        else $error("pins not at defaults after suspend");
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read data valid without a read");
    a_req_hold: assert property (s_req_open |=> mem_req
        && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before answer");
    a_undef_quiet: assert property (mem_req |->
        mem_table != srap_pkg::COL_BAD && mem_color != srap_pkg::COL_BAD)
        else $error("memory request with undefined selection");
    a_gamma_top: assert property (
        mem_req && mem_table == srap_pkg::TGT_GAMMA
        |-> mem_addr <= srap_pkg::GAMMA_TOP)
        else $error("gamma address beyond its top");
    a_idle_stop: assert property (s_idle_two |-> !acquire_active)
        else $error("engine active while command is idle");
endmodule : srap_monitor

// [verification/srap_mem_model.sv]
// table memory model answering the window's word requests
`timescale 1ns/1ps
module srap_mem_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // pace of answers
    input  wire logic        slow,
    // request side
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [1:0]  mem_table,
    input  wire logic [1:0]  mem_color,
    input  wire logic [13:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    // answer side
    output logic             mem_ack,
    output logic      [15:0] mem_rdata
);
    logic [15:0] mem [0:262143];
    logic [3:0]  wait_cnt;
    always @(posedge mclk) begin
        if (rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h5555;
            wait_cnt  <= 4'h0;
        end else if (mem_req && !mem_ack && wait_cnt == 4'h0) begin
            mem_ack <= 1'b1;
            if (mem_we)
                mem[{mem_table, mem_color, mem_addr}] <= mem_wdata;
            else
                mem_rdata <= mem[{mem_table, mem_color, mem_addr}];
        end else begin
            // data only holds in the answer cycle
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_ack)
                wait_cnt <= slow ? 4'h6 : 4'h0;
            else if (mem_req)
                wait_cnt <= wait_cnt - 4'h1;
        end
    end
endmodule : srap_mem_model

// [verification/tb.sv]
// self-checking bench for the scanner register access port
`timescale 1ns/1ps
module tb;
    logic        mclk = 1'b0, rst = 1'b1, suspend = 1'b0;
    logic        soft_hold = 1'b0, slow = 1'b0, line_tick = 1'b0;
    logic        reg_addr_wr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, command;
    logic        reg_rvalid, mem_req, mem_we, mem_ack, acquire_active;
    logic [1:0]  mem_table, mem_color;
    logic [13:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    logic        sense1_pin = 1'b1, sense2_pin = 1'b1;
    logic [5:0]  gpio_in = 6'h3f, gpio_out, gpio_oe;
    int          n_mismatch = 0, check_count = 0;
    int          seed = 32'h753ab15c;
    logic [7:0]  exp_q[$];
    always #4 mclk = ~mclk;
    srap_top srap_top_inst (.*);
    srap_mem_model srap_mem_model_inst (.*);
    task automatic check(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // kind 0 address, 1 write, 2 read; one idle cycle follows
    task automatic op(input int k, input logic [7:0] d);
        @(negedge mclk);
        reg_wdata = d;
        {reg_addr_wr, reg_wr, reg_rd} = {k == 0, k == 1, k == 2};
        @(negedge mclk);
        {reg_addr_wr, reg_wr, reg_rd} = 3'b000;
    endtask : op
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        op(0, {1'b0, a});
        op(1, d);
    endtask : wreg
    task automatic rbyte(input logic [7:0] e);
        exp_q.push_back(e);
        op(2, 8'h00);
        repeat (8) @(negedge mclk);
    endtask : rbyte
    task automatic rreg(input logic [6:0] a, input logic [7:0] e);
        op(0, {1'b0, a});
        rbyte(e);
    endtask : rreg
    task automatic wword(input logic [15:0] w);
        @(negedge mclk);
        {reg_wr, reg_wdata} = {1'b1, w[15:8]};
        @(negedge mclk);
        reg_wdata = w[7:0];
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wword
    task automatic win(input logic [1:0] t, c, input logic rd,
                       input logic [13:0] a);
        wreg(srap_pkg::REG_TGTCOL, {4'h0, c, t});
        wreg(srap_pkg::REG_WADDR_HI, {1'b0, rd, a[13:8]});
        wreg(srap_pkg::REG_WADDR_LO, a[7:0]);
        op(0, {1'b0, srap_pkg::REG_WDATA});
        repeat (12) @(negedge mclk);
    endtask : win
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge mclk) line_tick = 1'b1;
            @(negedge mclk) line_tick = 1'b0;
        end
    endtask : ticks
    always @(negedge mclk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("spare read", 16'h1, 16'h0);
            else check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [15:0] w;
        logic [13:0] a;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        check("gpio_oe", gpio_oe, srap_pkg::DEF_DIR);
        check("gpio_out", gpio_out, srap_pkg::DEF_OUT);
        for (int t = 0; t < 3; t++) for (int c = 0; c < 3; c++) begin
            w = 16'($random(seed));
            if (t == 0) w[1:0] = 2'b00;
            if (t == 2) w[15:12] = 4'h0;
            a = 14'($random(seed));
            if (t == 2) a = a % 14'd4094;
            slow = c[0];
            win(t[1:0], c[1:0], 1'b0, a);
            wword(w);
            repeat (20) @(negedge mclk);
            check("stored word", srap_mem_model_inst.mem[{t[1:0], c[1:0], a}],
                  w);
            win(t[1:0], c[1:0], 1'b1, a);
            rbyte(w[15:8]);
            rbyte(w[7:0]);
        end
        // two words back to back against a slow memory, across the top
        slow = 1'b1;
        win(srap_pkg::TGT_GAMMA, 2'h1, 1'b0, srap_pkg::GAMMA_TOP);
        wword(16'h0abc);
        wword(16'h0123);
        repeat (40) @(negedge mclk);
        check("wrap top", srap_mem_model_inst.mem[{4'h9, 14'h0ffd}],
              16'h0abc);
        check("wrap zero", srap_mem_model_inst.mem[{4'h9, 14'h0000}],
              16'h0123);
        win(2'h3, 2'h0, 1'b0, 14'h0000);
        wword(16'h5a5a);
        win(2'h0, srap_pkg::COL_BAD, 1'b1, 14'h0000);
        check("undef wr", srap_mem_model_inst.mem[18'h30000], 'x);
        rbyte(8'h00);
        rbyte(8'h00);
        wreg(srap_pkg::REG_SENSE_CFG, 8'h00);
        rreg(srap_pkg::REG_PIN_EDGE, {2'b00, srap_pkg::DEF_EDGE});
        rbyte({2'b00, srap_pkg::DEF_EDGE});
        rreg(7'h10, 8'h00);
        rreg(srap_pkg::REG_STATUS, 8'h00);
        @(negedge mclk) gpio_in[1] = 1'b0;
        repeat (6) @(negedge mclk);
        gpio_in[1] = 1'b1;
        repeat (6) @(negedge mclk);
        rbyte(8'h08);
        rbyte(8'h00);
        wreg(srap_pkg::REG_PIN_EDGE, 8'h00);
        wreg(srap_pkg::REG_PIN_POL, 8'h01);
        rreg(srap_pkg::REG_STATUS, 8'h04);
        rbyte(8'h04);
        @(negedge mclk) gpio_in[0] = 1'b0;
        repeat (6) @(negedge mclk);
        rbyte(8'h00);
        soft_hold = 1'b1;
        wreg(srap_pkg::REG_PIN_DIR, 8'h3f);
        wreg(srap_pkg::REG_PIN_OUT, {2'b00, w[5:0]});
        check("gpio_oe", gpio_oe, 6'h3f);
        check("gpio_out", gpio_out, w[5:0]);
        wreg(srap_pkg::REG_S2_LINES, 8'h02);
        @(negedge mclk) suspend = 1'b1;
        @(negedge mclk) suspend = 1'b0;
        soft_hold = 1'b0;
        check("gpio_oe", gpio_oe, srap_pkg::DEF_DIR);
        check("gpio_out", gpio_out, srap_pkg::DEF_OUT);
        // both sense stops on, active high, level
        {sense1_pin, sense2_pin} = 2'b00;
        wreg(srap_pkg::REG_SENSE_CFG, 8'h0f);
        wreg(srap_pkg::REG_COMMAND, srap_pkg::CMD_FREV);
        check("command", command, srap_pkg::CMD_FREV);
        @(negedge mclk) sense2_pin = 1'b1;
        repeat (6) @(negedge mclk);
        ticks(4);
        check("reverse runs", acquire_active, 1'b1);
        wreg(srap_pkg::REG_COMMAND, srap_pkg::CMD_IDLE);
        check("idle stops", acquire_active, 1'b0);
        sense2_pin = 1'b0;
        repeat (6) @(negedge mclk);
        wreg(srap_pkg::REG_COMMAND, srap_pkg::CMD_FFWD);
        sense2_pin = 1'b1;
        repeat (6) @(negedge mclk);
        ticks(1);
        check("forward runs", acquire_active, 1'b1);
        ticks(1);
        @(negedge mclk);
        check("delayed stop", acquire_active, 1'b0);
        wreg(srap_pkg::REG_COMMAND, srap_pkg::CMD_FFWD);
        @(negedge mclk) sense1_pin = 1'b1;
        for (int i = 0; i < 20 && acquire_active !== 1'b0; i++)
            @(negedge mclk);
        check("sense stop", acquire_active, 1'b0);
        repeat (10) @(negedge mclk);
        check("notes left", exp_q.size(), 16'h0);
        wrap_up();
    end
endmodule : tb
bind srap_top srap_monitor srap_monitor_inst (.*);
